// ==== design/fpu_pkg.sv ====
// Package of constants and types for the flash program unlock and address block.
// How it works
// R01 - Flash erase pages are 4 KB, 1024 instruction words; page erase clears one page.
// R02 - Row program writes one 512-byte row of 128 instruction words.
// R03 - Unlock key register is write-only and always reads back as zero.
// R04 - Software writes the unlock key sequence before any flash modification.
// R05 - Bulk or chip erase ignores the flash target address completely.
// R06 - Page erase uses the target address to select the page.
// R07 - Row program uses the target address to select the row.
// R08 - Word program uses the target address to select the single word.
// R09 - Operations start only right after a correct key pair; one attempt re-locks. The arm here stays open through other writes until a start or key write.
package fpu_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] FPU_OFS_CTRL = 4'h0;
	localparam logic [3:0] FPU_OFS_KEY = 4'h4;
	localparam logic [3:0] FPU_OFS_ADDR = 4'h8;
	localparam logic [3:0] FPU_OFS_STAT = 4'hC;
	localparam logic [31:0] FPU_RST_ADDR = 32'h0000_0000;
	localparam logic [31:0] FPU_KEY1 = 32'hAA99_6655;
	localparam logic [31:0] FPU_KEY2 = 32'h5566_99AA;
	// Control field positions: bit 0 starts, bits 2:1 choose the operation.
	localparam int FPU_CTRL_GO_BIT = 0;
	localparam int FPU_CTRL_OP_LSB = 1;
	// Status field positions.
	localparam int FPU_STAT_BUSY_BIT = 0;
	localparam int FPU_STAT_UNLK_BIT = 1;
	localparam int FPU_STAT_ERR_BIT = 2;
	localparam int FPU_STAT_DONE_BIT = 3;
	// ****************************************
	// Flash geometry in bytes
	// ****************************************
	localparam int FPU_PAGE_BYTES = 4096;
	localparam int FPU_ROW_BYTES = 512;
	localparam int FPU_WORD_BYTES = 4;
	localparam int FPU_PAGE_WORDS = FPU_PAGE_BYTES / FPU_WORD_BYTES;
	localparam int FPU_ROW_WORDS = FPU_ROW_BYTES / FPU_WORD_BYTES;
	localparam logic [31:0] FPU_PAGE_MASK = ~(32'(FPU_PAGE_BYTES) - 32'h1);
	localparam logic [31:0] FPU_ROW_MASK = ~(32'(FPU_ROW_BYTES) - 32'h1);
	localparam logic [31:0] FPU_WORD_MASK = ~(32'(FPU_WORD_BYTES) - 32'h1);
	typedef enum logic [1:0] {
		FPU_OP_WORD = 2'b00,
		FPU_OP_ROW = 2'b01,
		FPU_OP_PAGE = 2'b10,
		FPU_OP_BULK = 2'b11
	} fpu_op_e;
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} fpu_bus_s;
	typedef struct packed {
		logic valid;
		fpu_op_e op;
		logic [31:0] base;
		logic [10:0] words;
	} fpu_cmd_s;
endpackage

// ==== design/fpu_key_lock.sv ====
// Unlock key sequence checker for the flash program block.
`timescale 1ns/1ps
module fpu_key_lock
	import fpu_pkg::*;
(
	input wire logic core_clk, // System clock.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic key_wr, // Write strobe to the key register.
	input wire logic [31:0] key_data, // Key value written.
	input wire logic other_wr, // Any other register write.
	input wire logic attempt, // Operation start attempt.
	output logic unlocked // Armed for one attempt.
);
	typedef enum logic [1:0] {
		FPU_LK_IDLE = 2'b00,
		FPU_LK_HALF = 2'b01,
		FPU_LK_OPEN = 2'b10
	} fpu_lk_e;
	fpu_lk_e st_r, st_nxt;

	// ****************************************
	// Sequence tracking
	// ****************************************
	// A write to any other register between the two keys breaks the sequence, which keeps stray code from arming it.
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			FPU_LK_IDLE: begin
				// R04 key sequence start
				if (key_wr && key_data == FPU_KEY1) begin
					st_nxt = FPU_LK_HALF;
				end
			end
			FPU_LK_HALF: begin
				if (key_wr) begin
					st_nxt = (key_data == FPU_KEY2) ? FPU_LK_OPEN : FPU_LK_IDLE;
				end else if (other_wr) begin
					st_nxt = FPU_LK_IDLE;
				end
			end
			FPU_LK_OPEN: begin
				// R09 re-lock after one attempt
				if (attempt || key_wr) begin
					st_nxt = FPU_LK_IDLE;
				end
			end
			default: st_nxt = FPU_LK_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= FPU_LK_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign unlocked = (st_r == FPU_LK_OPEN);

	property p_relock;
		@(posedge core_clk) disable iff (!resetn)
		(unlocked && attempt) |=> !unlocked;
	endproperty
	a_relock: assert property (p_relock) else $error("Lock not restored after attempt."); // R09

	property p_two_keys;
		@(posedge core_clk) disable iff (!resetn)
		$rose(unlocked) |-> $past(key_wr) && $past(key_data) == FPU_KEY2;
	endproperty
	a_two_keys: assert property (p_two_keys) else $error("Unlocked without second key."); // R04
endmodule

// ==== design/fpu_target_calc.sv ====
// Target region calculation from the flash address and operation kind.
`timescale 1ns/1ps
module fpu_target_calc
	import fpu_pkg::*;
(
	input wire fpu_op_e op, // Operation kind.
	input wire logic [31:0] addr, // Flash target address.
	output logic [31:0] base, // First byte address touched.
	output logic [10:0] words // Instruction words touched.
);
	always_comb begin
		unique case (op)
			FPU_OP_BULK: begin
				// R05 address ignored
				base = 32'h0000_0000;
				words = 11'h000;
			end
			FPU_OP_PAGE: begin
				// R06 page select
				base = addr & FPU_PAGE_MASK;
				// R01 page of 1024 words
				words = 11'(FPU_PAGE_WORDS);
			end
			FPU_OP_ROW: begin
				// R07 row select
				base = addr & FPU_ROW_MASK;
				// R02 row of 128 words
				words = 11'(FPU_ROW_WORDS);
			end
			FPU_OP_WORD: begin
				// R08 word select
				base = addr & FPU_WORD_MASK;
				words = 11'h001;
			end
		endcase
	end
endmodule

// ==== design/fpu_top.sv ====
// Flash program unlock and target address register block.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module fpu_top
	import fpu_pkg::*;
#(
	parameter int BUSY_CYCLES = 16
) (
	input wire logic core_clk, // System clock, 40 MHz.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic [3:0] reg_addr, // Register byte address.
	input wire logic [31:0] reg_wdata, // Write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	output logic [31:0] reg_rdata, // Read data, one cycle after strobe.
	output fpu_cmd_s flash_cmd, // One-cycle operation request to the array.
	output logic flash_busy // Operation in progress.
);
	// The busy counter is 16 bits wide, so longer operations cannot be timed.
	if (BUSY_CYCLES < 1 || BUSY_CYCLES > 65535) begin : g_busy_range
		$error("BUSY_CYCLES out of range.");
	end

	fpu_bus_s bus;
	logic [31:0] addr_r, addr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	fpu_cmd_s cmd_r, cmd_nxt;
	logic busy_r, busy_nxt;
	logic err_r, err_nxt;
	logic done_r, done_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic key_wr, ctrl_wr, go, unlocked;
	logic [31:0] t_base;
	logic [10:0] t_words;
	fpu_op_e op_sel;

	assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign key_wr = bus.wr && bus.addr == FPU_OFS_KEY;
	assign ctrl_wr = bus.wr && bus.addr == FPU_OFS_CTRL;
	assign go = ctrl_wr && bus.wdata[FPU_CTRL_GO_BIT];
	assign op_sel = fpu_op_e'(bus.wdata[FPU_CTRL_OP_LSB +: 2]);

	fpu_key_lock u_lock (
		.core_clk(core_clk),
		.resetn(resetn),
		.key_wr(key_wr),
		.key_data(bus.wdata),
		.other_wr(bus.wr && !key_wr),
		.attempt(go),
		.unlocked(unlocked)
	);

	fpu_target_calc u_calc (
		.op(op_sel),
		.addr(addr_r),
		.base(t_base),
		.words(t_words)
	);

	// ****************************************
	// Registers and operation launch
	// ****************************************
	always_comb begin
		addr_nxt = addr_r;
		cmd_nxt = '0;
		busy_nxt = busy_r;
		err_nxt = err_r;
		done_nxt = done_r;
		cnt_nxt = cnt_r;
		rdata_nxt = 32'h0000_0000;
		if (bus.wr && bus.addr == FPU_OFS_ADDR) begin
			addr_nxt = bus.wdata;
		end
		if (busy_r) begin
			if (cnt_r == 16'h0001) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
			cnt_nxt = cnt_r - 16'h0001;
		end
		if (go) begin
			// R09 start only when armed
			if (unlocked && !busy_r) begin
				cmd_nxt = '{valid: 1'b1, op: op_sel, base: t_base, words: t_words};
				busy_nxt = 1'b1;
				done_nxt = 1'b0;
				err_nxt = 1'b0;
				cnt_nxt = 16'(BUSY_CYCLES);
			end else begin
				err_nxt = 1'b1;
			end
		end
		if (bus.rd) begin
			unique case (bus.addr)
				FPU_OFS_ADDR: rdata_nxt = addr_r;
				FPU_OFS_STAT: begin
					rdata_nxt[FPU_STAT_BUSY_BIT] = busy_r;
					rdata_nxt[FPU_STAT_UNLK_BIT] = unlocked;
					rdata_nxt[FPU_STAT_ERR_BIT] = err_r;
					rdata_nxt[FPU_STAT_DONE_BIT] = done_r;
				end
				// R03 key reads zero
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			addr_r <= FPU_RST_ADDR;
			rdata_r <= 32'h0000_0000;
			cmd_r <= '0;
			busy_r <= 1'b0;
			err_r <= 1'b0;
			done_r <= 1'b0;
			cnt_r <= 16'h0000;
		end else begin
			addr_r <= addr_nxt;
			rdata_r <= rdata_nxt;
			cmd_r <= cmd_nxt;
			busy_r <= busy_nxt;
			err_r <= err_nxt;
			done_r <= done_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign flash_cmd = cmd_r;
	assign flash_busy = busy_r;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_armed_go;
		unlocked && go && !busy_r;
	endsequence

	property p_key_reads_zero;
		@(posedge core_clk) disable iff (!resetn)
		(reg_rd && reg_addr == FPU_OFS_KEY) |=> reg_rdata == 32'h0000_0000;
	endproperty
	a_key_reads_zero: assert property (p_key_reads_zero) else $error("Key register read nonzero."); // R03

	property p_locked_no_cmd;
		@(posedge core_clk) disable iff (!resetn)
		(go && !unlocked) |=> !flash_cmd.valid && err_r;
	endproperty
	a_locked_no_cmd: assert property (p_locked_no_cmd) else $error("Command issued while locked."); // R09

	property p_launch;
		@(posedge core_clk) disable iff (!resetn)
		s_armed_go |=> flash_cmd.valid && flash_busy;
	endproperty
	a_launch: assert property (p_launch) else $error("Armed start did not launch."); // R04

	property p_bulk;
		@(posedge core_clk) disable iff (!resetn)
		(flash_cmd.valid && flash_cmd.op == FPU_OP_BULK) |-> flash_cmd.base == 32'h0000_0000;
	endproperty
	a_bulk: assert property (p_bulk) else $error("Bulk erase used address."); // R05

	property p_page;
		@(posedge core_clk) disable iff (!resetn)
		(flash_cmd.valid && flash_cmd.op == FPU_OP_PAGE) |->
			flash_cmd.words == 11'd1024 && flash_cmd.base == ($past(addr_r) & 32'hFFFF_F000);
	endproperty
	a_page: assert property (p_page) else $error("Page erase target wrong."); // R06

	property p_page_size;
		@(posedge core_clk) disable iff (!resetn)
		(flash_cmd.valid && flash_cmd.op == FPU_OP_PAGE) |-> flash_cmd.base[11:0] == 12'h000;
	endproperty
	a_page_size: assert property (p_page_size) else $error("Page not 4 KB aligned."); // R01

	property p_row;
		@(posedge core_clk) disable iff (!resetn)
		(flash_cmd.valid && flash_cmd.op == FPU_OP_ROW) |->
			flash_cmd.words == 11'd128 && flash_cmd.base == ($past(addr_r) & 32'hFFFF_FE00);
	endproperty
	a_row: assert property (p_row) else $error("Row program target wrong."); // R07

	property p_row_size;
		@(posedge core_clk) disable iff (!resetn)
		(flash_cmd.valid && flash_cmd.op == FPU_OP_ROW) |-> flash_cmd.base[8:0] == 9'h000;
	endproperty
	a_row_size: assert property (p_row_size) else $error("Row not 512 byte aligned."); // R02

	property p_word;
		@(posedge core_clk) disable iff (!resetn)
		(flash_cmd.valid && flash_cmd.op == FPU_OP_WORD) |->
			flash_cmd.words == 11'd1 && flash_cmd.base == ($past(addr_r) & 32'hFFFF_FFFC);
	endproperty
	a_word: assert property (p_word) else $error("Word program target wrong."); // R08

	property p_cmd_pulse;
		@(posedge core_clk) disable iff (!resetn)
		flash_cmd.valid |=> !flash_cmd.valid;
	endproperty
	a_cmd_pulse: assert property (p_cmd_pulse) else $error("Command longer than one cycle."); // R09

	// ****************************************
	// Launch, busy and register file checks
	// ****************************************
	// These tie status and counter to the launch, so a stuck busy bit cannot pass unnoticed.
	sequence s_launched;
		s_armed_go ##1 flash_busy;
	endsequence

	sequence s_busy_last;
		flash_busy && cnt_r == 16'h0001;
	endsequence

	// A launch consumes the arm and starts a fresh count with clean flags.
	property p_launch_relocks;
		@(posedge core_clk) disable iff (!resetn)
		s_launched |-> !unlocked && cnt_r == 16'(BUSY_CYCLES) && !done_r && !err_r;
	endproperty
	a_launch_relocks: assert property (p_launch_relocks) else $error("Launch state wrong."); // R09

	property p_busy_end;
		@(posedge core_clk) disable iff (!resetn)
		s_busy_last |=> !flash_busy && done_r;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("Busy did not end with done."); // R09

	// The counter must step down by one each cycle, or the operation time drifts.
	property p_busy_stays;
		@(posedge core_clk) disable iff (!resetn)
		(flash_busy && cnt_r != 16'h0001) |=>
			flash_busy && cnt_r == $past(cnt_r) - 16'h0001;
	endproperty
	a_busy_stays: assert property (p_busy_stays) else $error("Busy ended early."); // R09

	// A start during busy is refused even when armed, so a running operation is never retargeted.
	property p_busy_refused;
		@(posedge core_clk) disable iff (!resetn)
		(go && busy_r) |=> !flash_cmd.valid && err_r;
	endproperty
	a_busy_refused: assert property (p_busy_refused) else $error("Start accepted while busy."); // R09

	property p_cmd_needs_arm;
		@(posedge core_clk) disable iff (!resetn)
		flash_cmd.valid |-> $past(unlocked);
	endproperty
	a_cmd_needs_arm: assert property (p_cmd_needs_arm) else $error("Command without unlock."); // R04

	// The array sees zero fields between requests, so a stale target cannot leak through.
	property p_cmd_idle_zero;
		@(posedge core_clk) disable iff (!resetn)
		!flash_cmd.valid |-> flash_cmd.base == 32'h0000_0000 && flash_cmd.words == 11'h000;
	endproperty
	a_cmd_idle_zero: assert property (p_cmd_idle_zero) else $error("Idle command fields nonzero."); // R09

	property p_bulk_words;
		@(posedge core_clk) disable iff (!resetn)
		(flash_cmd.valid && flash_cmd.op == FPU_OP_BULK) |-> flash_cmd.words == 11'h000;
	endproperty
	a_bulk_words: assert property (p_bulk_words) else $error("Bulk erase carried a size."); // R05

	// The address register takes every write to its offset whole.
	property p_addr_write;
		@(posedge core_clk) disable iff (!resetn)
		(reg_wr && reg_addr == FPU_OFS_ADDR) |=> addr_r == $past(reg_wdata);
	endproperty
	a_addr_write: assert property (p_addr_write) else $error("Address write lost."); // R06

	// A write to any other offset must leave the address alone.
	property p_addr_hold;
		@(posedge core_clk) disable iff (!resetn)
		!(reg_wr && reg_addr == FPU_OFS_ADDR) |=> $stable(addr_r);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("Address changed without a write."); // R07

	property p_addr_read;
		@(posedge core_clk) disable iff (!resetn)
		(reg_rd && reg_addr == FPU_OFS_ADDR) |=> reg_rdata == $past(addr_r);
	endproperty
	a_addr_read: assert property (p_addr_read) else $error("Address read wrong."); // R08

	property p_ctrl_reads_zero;
		@(posedge core_clk) disable iff (!resetn)
		(reg_rd && reg_addr == FPU_OFS_CTRL) |=> reg_rdata == 32'h0000_0000;
	endproperty
	a_ctrl_reads_zero: assert property (p_ctrl_reads_zero) else $error("Control read nonzero."); // R03

	// Read data stands for one cycle only, so software cannot pick up a stale value.
	property p_rdata_idle;
		@(posedge core_clk) disable iff (!resetn)
		!reg_rd |=> reg_rdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("Read data held too long."); // R03

	// Status bits mirror the state one cycle after the read strobe; the rest read zero.
	property p_stat_read;
		@(posedge core_clk) disable iff (!resetn)
		(reg_rd && reg_addr == FPU_OFS_STAT) |=>
			reg_rdata[31:4] == 28'h000_0000 &&
			reg_rdata[FPU_STAT_BUSY_BIT] == $past(busy_r) &&
			reg_rdata[FPU_STAT_UNLK_BIT] == $past(unlocked) &&
			reg_rdata[FPU_STAT_ERR_BIT] == $past(err_r) &&
			reg_rdata[FPU_STAT_DONE_BIT] == $past(done_r);
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("Status read wrong."); // R09
endmodule

// ==== verif/tb.sv ====
// Self-checking testbench for the flash program unlock and address block.
`timescale 1ns/1ps
module tb;
	import fpu_pkg::*;
	localparam int BUSY = 4;
	logic core_clk;
	logic resetn;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	fpu_cmd_s flash_cmd;
	logic flash_busy;
	int n_mismatch;
	int total_checks;

	// A short busy time keeps every launch quick while the count is still checked.
	fpu_top #(.BUSY_CYCLES(BUSY)) dut (
		.core_clk(core_clk),
		.resetn(resetn),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.flash_cmd(flash_cmd),
		.flash_busy(flash_busy)
	);

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task unlock;
		wr(FPU_OFS_KEY, FPU_KEY1);
		wr(FPU_OFS_KEY, FPU_KEY2);
	endtask

	// Both keys on consecutive cycles, the tightest spacing the bus allows.
	task unlock_b2b;
		@(posedge core_clk);
		reg_addr <= FPU_OFS_KEY;
		reg_wdata <= FPU_KEY1;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wdata <= FPU_KEY2;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// Counts the cycles that busy stands and checks that the request lasted one cycle.
	task busy_len(input int exp);
		int n;
		n = 0;
		while (flash_busy === 1'b1 && n < 100) begin
			@(posedge core_clk);
			#1;
			n++;
			if (n == 1) begin
				chk("valid_one_cycle", 32'h0, {31'h0, flash_cmd.valid});
			end
		end
		if (n >= 100) begin
			n_mismatch++;
			$display("mismatch busy_wait expected %0d seen timeout", exp);
			end_sim;
		end
		chk("busy_cycles", exp, n);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		logic [31:0] d;
		chk("cmd_after_reset", 32'h0, {31'h0, flash_cmd.valid});
		rd(FPU_OFS_ADDR, d);
		chk("addr_reset", 32'h0000_0000, d);
		rd(FPU_OFS_KEY, d);
		chk("key_reset", 32'h0000_0000, d);
		rd(FPU_OFS_STAT, d);
		chk("stat_reset", 32'h0000_0000, d);
	endtask

	task t_regs;
		logic [31:0] d;
		wr(FPU_OFS_ADDR, 32'hA5C3_5A7E);
		rd(FPU_OFS_ADDR, d);
		chk("addr_rw", 32'hA5C3_5A7E, d);
		wr(FPU_OFS_KEY, 32'hFFFF_FFFF);
		rd(FPU_OFS_KEY, d);
		chk("key_wo", 32'h0000_0000, d);
		wr(4'h2, 32'h1234_5678);
		rd(4'h2, d);
		chk("unmapped_rd", 32'h0000_0000, d);
		rd(FPU_OFS_ADDR, d);
		chk("unmapped_wr", 32'hA5C3_5A7E, d);
	endtask

	// Every operation kind, with bases and sizes worked out from the flash geometry.
	task t_ops;
		logic [31:0] a;
		logic [31:0] d;
		logic [31:0] eb [4];
		logic [31:0] ew [4];
		a = 32'h0003_5A7E;
		eb = '{a & ~32'h3, a & ~32'h1FF, a & ~32'hFFF, 32'h0};
		ew = '{32'd1, 32'd128, 32'd1024, 32'd0};
		for (int op = 0; op < 4; op++) begin
			wr(FPU_OFS_ADDR, a);
			unlock();
			wr(FPU_OFS_CTRL, {29'h0, 2'(op), 1'b1});
			chk("cmd_valid", 32'h1, {31'h0, flash_cmd.valid});
			chk("cmd_op", op, {30'h0, flash_cmd.op});
			chk("cmd_base", eb[op], flash_cmd.base);
			chk("cmd_words", ew[op], {21'h0, flash_cmd.words});
			chk("busy_up", 32'h1, {31'h0, flash_busy});
			busy_len(BUSY);
			rd(FPU_OFS_STAT, d);
			chk("stat_done", 32'h8, d & 32'hB);
		end
	endtask

	task t_refuse;
		logic [31:0] d;
		wr(FPU_OFS_CTRL, 32'h7);
		chk("locked_go", 32'h0, {31'h0, flash_cmd.valid});
		chk("locked_busy", 32'h0, {31'h0, flash_busy});
		rd(FPU_OFS_STAT, d);
		chk("stat_err", 32'h4, d & 32'h7);
		wr(FPU_OFS_KEY, FPU_KEY1);
		wr(FPU_OFS_ADDR, 32'h0000_1000);
		wr(FPU_OFS_KEY, FPU_KEY2);
		wr(FPU_OFS_CTRL, 32'h5);
		chk("broken_seq", 32'h0, {31'h0, flash_cmd.valid});
		wr(FPU_OFS_KEY, FPU_KEY1);
		wr(FPU_OFS_KEY, FPU_KEY1);
		wr(FPU_OFS_CTRL, 32'h5);
		chk("bad_key2", 32'h0, {31'h0, flash_cmd.valid});
		unlock();
		wr(FPU_OFS_CTRL, 32'h3);
		chk("relaunch", 32'h1, {31'h0, flash_cmd.valid});
		busy_len(BUSY);
		wr(FPU_OFS_CTRL, 32'h3);
		chk("relock", 32'h0, {31'h0, flash_cmd.valid});
	endtask

	// Gap-free keys arm, an address write keeps the arm, a start during busy or after a stray key is refused.
	task t_arm;
		logic [31:0] d;
		unlock_b2b();
		rd(FPU_OFS_STAT, d);
		chk("stat_unlocked", 32'h2, d & 32'h2);
		@(posedge core_clk);
		#1;
		chk("rdata_stands", 32'h0, reg_rdata);
		wr(FPU_OFS_ADDR, 32'h0000_2345);
		wr(FPU_OFS_CTRL, 32'h5);
		chk("addr_keeps_arm", 32'h1, {31'h0, flash_cmd.valid});
		chk("page_base", 32'h0000_2000, flash_cmd.base);
		wr(FPU_OFS_CTRL, 32'h5);
		chk("busy_go", 32'h0, {31'h0, flash_cmd.valid});
		busy_len(BUSY - 2);
		chk("cmd_idle_base", 32'h0, flash_cmd.base);
		rd(FPU_OFS_STAT, d);
		chk("stat_busy_err", 32'h4, d & 32'h7);
		wr(FPU_OFS_KEY, FPU_KEY1);
		rd(FPU_OFS_STAT, d);
		wr(FPU_OFS_KEY, FPU_KEY2);
		rd(FPU_OFS_STAT, d);
		chk("read_between_keys", 32'h2, d & 32'h2);
		wr(FPU_OFS_KEY, FPU_KEY1);
		wr(FPU_OFS_CTRL, 32'h5);
		chk("key_drops_arm", 32'h0, {31'h0, flash_cmd.valid});
	endtask

	// A reset in mid-run clears the address and the flags and closes an open lock.
	task t_mid_reset;
		logic [31:0] d;
		wr(FPU_OFS_ADDR, 32'h0001_2344);
		unlock();
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		#1;
		chk("busy_mid_reset", 32'h0, {31'h0, flash_busy});
		rd(FPU_OFS_ADDR, d);
		chk("addr_mid_reset", 32'h0000_0000, d);
		rd(FPU_OFS_STAT, d);
		chk("stat_mid_reset", 32'h0000_0000, d);
		wr(FPU_OFS_CTRL, 32'h1);
		chk("go_after_reset", 32'h0, {31'h0, flash_cmd.valid});
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		n_mismatch = 0;
		total_checks = 0;
		resetn = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		#1;
		t_reset();
		t_regs();
		t_ops();
		t_refuse();
		t_arm();
		t_mid_reset();
		end_sim();
	end
endmodule
